// File: core/bpc_pkg.sv
// Purpose: shared constants of the byte parity checker
// Assumes: one 100 MHz clock, APB register access
// Notes: byte addresses of the APB words are offsets below
`default_nettype none
package bpc_pkg;
  // ----------------------------------------
  // apb map
  // ----------------------------------------
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_CMD = 12'h004;
  // ----------------------------------------
  // command and reset values
  // ----------------------------------------
  localparam logic [3:0] CMD_RESET = 4'h0;
  localparam int SENSE_BIT_DEF = 0;
  localparam int IRQ_EN_BIT_DEF = 1;
  localparam int NMI_EN_BIT_DEF = 2;
  localparam int IND_EN_BIT_DEF = 3;
  // ----------------------------------------
  // address layout (vector holds address bits 1..15)
  // ----------------------------------------
  localparam int ADDR_W = 15;
  localparam int ADDR_A_POS = 9;
  localparam int IDX_W_DEF = 14;
  localparam int SYNC_STAGES = 2;
endpackage
`default_nettype wire

// File: core/bpc_checker.sv
// Purpose: byte-wise parity generate/check beside a dual-port dram
// Assumes: all base-board pins asynchronous, synchronised here
// Notes: parity store is flip-flops, one bit per byte per word
// Operation
// - two parity banks, picked by row strobe 0 (low half) or 1 (upper half)
// - raw generator output is low for odd ones count, high for even
// - raw output is xored with parity sense; odd mode keeps low as low
// - during writes the stored-bit input is low; result stored at cycle end
// - on reads stored bit joins the data; high corrected result means byte error
// - an error sets interrupt latches and high/low byte indicator latches
// - data captured on transfer ack rise, driven while dual-port read is low
// - maskable latch sets on any byte error at column strobe rise of a read
// - non-maskable latch sets likewise unless suppress holds it masked
// - active suppress clears and holds non-maskable latch; strap inverts level
// - maskable event clocks both byte errors into indicator latches
// - command taken at offset 0000h with address strap, 0400h without
// - all compared address bits zero, bit a one when strap absent
// - captured command steers sense, interrupt masking and indicators
// - command write also stores shadow word with parity of current sense
// - inverted sense makes every write store wrong parity
// - command bits captured on write-enable-one rise while decode true
// - reset clears command: interrupts and indicators masked, odd parity
// - maskable latch holds until command clears it or reset
//
// Local design decisions: the APB register port and the register offsets.
`default_nettype none
module bpc_checker #(
  parameter int IDX_W = bpc_pkg::IDX_W_DEF,
  parameter int SENSE_BIT = bpc_pkg::SENSE_BIT_DEF,
  parameter int IRQ_EN_BIT = bpc_pkg::IRQ_EN_BIT_DEF,
  parameter int NMI_EN_BIT = bpc_pkg::NMI_EN_BIT_DEF,
  parameter int IND_EN_BIT = bpc_pkg::IND_EN_BIT_DEF
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // base-board memory strobes
  input wire logic ROW_STROBE_BANK0_N_I,
  input wire logic ROW_STROBE_BANK1_N_I,
  input wire logic COLUMN_STROBE_N_I,
  input wire logic WRITE_STROBE_N_I,
  input wire logic WRITE_ENABLE_ONE_N_I,
  input wire logic TRANSFER_ACK_N_I,
  input wire logic DUAL_PORT_READ_N_I,
  input wire logic NONMASKABLE_SUPPRESS_I,
  // base-board address and data
  input wire logic [bpc_pkg::ADDR_W-1:0] MEMORY_ADDRESS_BITS_I,
  input wire logic [15:0] DATA_I,
  output logic [15:0] DATA_O,
  output logic DATA_OE_O,
  // straps
  input wire logic ADDRESS_STRAP_I,
  input wire logic POLARITY_STRAP_I,
  // interrupts and indicators
  output logic MASKABLE_ERROR_IRQ_O,
  output logic NONMASKABLE_ERROR_IRQ_O,
  output logic HIGH_BYTE_ERROR_O,
  output logic LOW_BYTE_ERROR_O
);
  // elaboration-time refusal of parameter values the logic cannot serve
  if (IDX_W < 1 || IDX_W > 14)
  begin
    $error("IDX_W out of range");
  end
  if (SENSE_BIT == IRQ_EN_BIT || SENSE_BIT == NMI_EN_BIT || SENSE_BIT == IND_EN_BIT ||
      IRQ_EN_BIT == NMI_EN_BIT || IRQ_EN_BIT == IND_EN_BIT || NMI_EN_BIT == IND_EN_BIT ||
      SENSE_BIT > 3 || IRQ_EN_BIT > 3 || NMI_EN_BIT > 3 || IND_EN_BIT > 3)
  begin
    $error("command bit positions must be distinct and below 4");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  always_ff @(posedge CLOCK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PW = 10 + bpc_pkg::ADDR_W + 16;
  logic [PW-1:0] pin_meta_r;
  logic [PW-1:0] pin_s_r;
  logic [9:0] strb_prev_r;
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_r <= {PW{1'b1}};
      pin_s_r <= {PW{1'b1}};
      strb_prev_r <= 10'h3ff;
    end
    else
    begin
      pin_meta_r <= {ROW_STROBE_BANK0_N_I, ROW_STROBE_BANK1_N_I, COLUMN_STROBE_N_I,
                     WRITE_STROBE_N_I, WRITE_ENABLE_ONE_N_I, TRANSFER_ACK_N_I,
                     DUAL_PORT_READ_N_I, NONMASKABLE_SUPPRESS_I, ADDRESS_STRAP_I,
                     POLARITY_STRAP_I, MEMORY_ADDRESS_BITS_I, DATA_I};
      pin_s_r <= pin_meta_r;
      strb_prev_r <= pin_s_r[PW-1 -: 10];
    end
  end

  logic ras0_n_s, row_strobe_bank1_n_n_s, cas_n_s, wr_n_s, we1_n_s, transfer_ack_n_n_s, dual_port_read_n_n_s;
  logic supp_s, astrap_s, pstrap_s;
  logic [bpc_pkg::ADDR_W-1:0] addr_s;
  logic [15:0] data_s;
  assign {ras0_n_s, row_strobe_bank1_n_n_s, cas_n_s, wr_n_s, we1_n_s, transfer_ack_n_n_s, dual_port_read_n_n_s,
          supp_s, astrap_s, pstrap_s, addr_s, data_s} = pin_s_r;

  // rising edges of active-low strobes, seen one sample late
  wire cas_rise = cas_n_s && !strb_prev_r[7];
  wire we1_rise = we1_n_s && !strb_prev_r[5];
  wire transfer_ack_n_rise = transfer_ack_n_n_s && !strb_prev_r[4];

  // ----------------------------------------
  // parity arithmetic
  // ----------------------------------------
  // stored-bit input held low while writing, so one function serves both paths
  function automatic logic par_bit(input logic [7:0] d, input logic stored, input logic sense);
    logic raw;
    raw = ~(^{d, stored});
    par_bit = raw ^ sense;
  endfunction

  logic [3:0] cmd_r, cmd_nxt;
  logic [15:0] dlat_r;
  logic [1:0] par_r [2][2**IDX_W];
  wire sense = cmd_r[SENSE_BIT];
  wire irq_en = cmd_r[IRQ_EN_BIT];
  wire nmi_en = cmd_r[NMI_EN_BIT];
  wire ind_en = cmd_r[IND_EN_BIT];

  wire ras_any = !ras0_n_s || !row_strobe_bank1_n_n_s;
  wire bank = ras0_n_s;
  wire [IDX_W-1:0] idx = addr_s[IDX_W-1:0];
  wire [1:0] stored = par_r[bank][idx];
  wire writing = !wr_n_s;
  wire [1:0] st_in = writing ? 2'h0 : stored;
  wire [1:0] gen_bits = {par_bit(dlat_r[15:8], st_in[1], sense), par_bit(dlat_r[7:0], st_in[0], sense)};
  wire high_byte_error = !writing && gen_bits[1];
  wire low_byte_error = !writing && gen_bits[0];
  wire err_any = high_byte_error || low_byte_error;
  wire par_wr = cas_rise && writing && ras_any;
  wire rd_end = cas_rise && !writing && ras_any;
  wire irq_ev = rd_end && err_any && irq_en;

  // ----------------------------------------
  // parity store and data latch
  // ----------------------------------------
  // no reset on the store: contents are undefined at power-up, like the dram
  always_ff @(posedge CLOCK_I)
  begin
    if (par_wr)
      par_r[bank][idx] <= gen_bits;
  end

  logic oe_r;
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dlat_r <= 16'h0000;
      oe_r <= 1'b0;
    end
    else
    begin
      if (transfer_ack_n_rise)
        dlat_r <= data_s;
      oe_r <= !dual_port_read_n_n_s;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  wire [bpc_pkg::ADDR_W-1:0] a_want = (bpc_pkg::ADDR_W)'(!astrap_s) << bpc_pkg::ADDR_A_POS;
  wire dec_hit = (addr_s ^ a_want) == '0;
  wire mem_cmd_wr = we1_rise && dec_hit;
  wire apb_acc = PSEL_I && PENABLE_I && PREADY_O;
  wire apb_cmd_wr = apb_acc && PWRITE_I && PADDR_I == bpc_pkg::OFF_CMD;
  assign cmd_nxt = mem_cmd_wr ? data_s[3:0] : apb_cmd_wr ? PWDATA_I[3:0] : cmd_r;

  // ----------------------------------------
  // error latches
  // ----------------------------------------
  logic irq_r, nmi_r, ind_hi_r, ind_lo_r;
  wire supp_act = supp_s ^ pstrap_s;
  wire irq_nxt = irq_en && (irq_r || irq_ev);
  wire nmi_nxt = nmi_en && !supp_act && (nmi_r || (rd_end && err_any));
  wire ind_hi_nxt = ind_en && (ind_hi_r || (irq_ev && high_byte_error));
  wire ind_lo_nxt = ind_en && (ind_lo_r || (irq_ev && low_byte_error));
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r <= bpc_pkg::CMD_RESET;
      irq_r <= 1'b0;
      nmi_r <= 1'b0;
      ind_hi_r <= 1'b0;
      ind_lo_r <= 1'b0;
    end
    else
    begin
      cmd_r <= cmd_nxt;
      irq_r <= irq_nxt;
      nmi_r <= nmi_nxt;
      ind_hi_r <= ind_hi_nxt;
      ind_lo_r <= ind_lo_nxt;
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait-free access phase: ready rises on the cycle after setup
  wire apb_setup = PSEL_I && !PENABLE_I;
  wire hit_st = PADDR_I == bpc_pkg::OFF_STATUS;
  wire hit_cmd = PADDR_I == bpc_pkg::OFF_CMD;
  wire [31:0] status_w = {24'h000000, ind_hi_r, ind_lo_r, nmi_r, irq_r, cmd_r};
  wire [31:0] rd_mux = hit_st ? status_w : hit_cmd ? {28'h0000000, cmd_r} : 32'h00000000;
  wire bad = !(hit_cmd || (hit_st && !PWRITE_I));
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= apb_setup;
      pslverr_r <= apb_setup && bad;
      prdata_r <= apb_setup && !PWRITE_I ? rd_mux : 32'h00000000;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign DATA_O = dlat_r;
  assign DATA_OE_O = oe_r;
  assign MASKABLE_ERROR_IRQ_O = irq_r;
  assign NONMASKABLE_ERROR_IRQ_O = nmi_r;
  assign HIGH_BYTE_ERROR_O = ind_hi_r;
  assign LOW_BYTE_ERROR_O = ind_lo_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!rst_n);

  a_irq_set: assert property (rd_end && err_any && irq_en |=> irq_r)
    else $error("maskable latch missed an error");
  a_irq_hold: assert property (irq_r && irq_en |=> irq_r)
    else $error("maskable latch dropped while enabled");
  a_cmd_mask: assert property (!irq_en && !ind_en |=> !irq_r && !ind_hi_r && !ind_lo_r)
    else $error("masked latches not cleared");
  a_nmi_set: assert property (rd_end && err_any && nmi_en && !supp_act |=> nmi_r)
    else $error("non-maskable latch missed an error");
  a_nmi_supp: assert property (supp_act [*2] |=> !nmi_r)
    else $error("suppress did not hold latch clear");
  a_cmd_cap: assert property (mem_cmd_wr |=> cmd_r == $past(data_s[3:0]))
    else $error("command not captured");
  a_dec_addr: assert property (dec_hit == (addr_s == (astrap_s ? 15'h0000 : 15'h0200)))
    else $error("decode hit on wrong address");
  a_par_write: assert property (par_wr |=> par_r[$past(bank)][$past(idx)] == $past(gen_bits))
    else $error("parity not stored");
  a_ind_cap: assert property (irq_ev && ind_en && high_byte_error |=> ind_hi_r)
    else $error("high indicator not set");
  a_data_lat: assert property (transfer_ack_n_rise ##1 !transfer_ack_n_rise |=> dlat_r == $past(data_s, 2))
    else $error("data latch lost capture");
  a_ev_edge: assert property ($rose(irq_r) |-> $past(cas_rise))
    else $error("maskable latch set without strobe edge");

  c_irq: cover property (irq_ev);
  c_nmi: cover property (rd_end && err_any && !supp_act && nmi_en);
  c_cmd: cover property (mem_cmd_wr);
  c_forced: cover property (par_wr && sense);
endmodule
`default_nettype wire

// File: testbench/bpc_mem_model.sv
// Purpose: base-board memory control model facing the parity checker
// Assumes: each strobe level held at least 4 clocks, well above the sync need
// Notes: released data lines show the inverse of the last value
`default_nettype none
module bpc_mem_model (
  // clock
  input wire logic clk_i,
  // strobes
  output logic row_strobe_bank0_n_o,
  output logic row_strobe_bank1_n_o,
  output logic column_strobe_n_o,
  output logic write_strobe_n_o,
  output logic write_enable_one_n_o,
  output logic transfer_ack_n_o,
  output logic dual_port_read_n_o,
  // address and data
  output logic [14:0] memory_address_bits_o,
  output logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {row_strobe_bank0_n_o, row_strobe_bank1_n_o, column_strobe_n_o, write_strobe_n_o} = 4'hf;
    {write_enable_one_n_o, transfer_ack_n_o, dual_port_read_n_o} = 3'h7;
    memory_address_bits_o = 15'h0000;
    data_o = 16'h0000;
  end
  task automatic step;
    repeat (4) @(posedge clk_i);
  endtask
  // ------------------------------------------
  // one memory cycle, bank picked by row strobe
  // ------------------------------------------
  task automatic cycle(input logic wr, input logic bank, input logic cmd, input logic [14:0] a, input logic [15:0] d);
    @(posedge clk_i);
    memory_address_bits_o <= a;
    data_o <= d;
    write_strobe_n_o <= ~wr;
    write_enable_one_n_o <= ~cmd;
    row_strobe_bank0_n_o <= bank;
    row_strobe_bank1_n_o <= ~bank;
    column_strobe_n_o <= 1'b0;
    transfer_ack_n_o <= 1'b0;
    step;
    transfer_ack_n_o <= 1'b1;
    step;
    column_strobe_n_o <= 1'b1;
    write_enable_one_n_o <= 1'b1;
    step;
    {row_strobe_bank0_n_o, row_strobe_bank1_n_o, write_strobe_n_o} <= 3'h7;
    // inverse, so a stale value cannot pass for fresh data
    data_o <= ~d;
    step;
  endtask
  task automatic read_port(input logic on);
    @(posedge clk_i);
    dual_port_read_n_o <= ~on;
    step;
  endtask
endmodule
`default_nettype wire

// File: testbench/byte_parity_checker_tb.sv
// Purpose: self-checking bench of the byte parity checker
// Assumes: parity store shrunk to 16 words per bank
// Notes: checks sample at the falling edge, after registered outputs settle
`default_nettype none
`define CHK(n, e, g) begin @(negedge clk); compares++; if ((g) !== (e)) begin failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module byte_parity_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, supp, astrap, pstrap, oe, irq, nmi, hi, lo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dout;
  wire logic rs0_n, rs1_n, cs_n, ws_n, we1_n, ack_n, dpr_n;
  wire logic [14:0] ma;
  wire logic [15:0] md;
  int failures = 0;
  int compares = 0;
  bpc_checker #(.IDX_W(4)) DUT (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .ROW_STROBE_BANK0_N_I(rs0_n), .ROW_STROBE_BANK1_N_I(rs1_n), .COLUMN_STROBE_N_I(cs_n),
    .WRITE_STROBE_N_I(ws_n), .WRITE_ENABLE_ONE_N_I(we1_n), .TRANSFER_ACK_N_I(ack_n),
    .DUAL_PORT_READ_N_I(dpr_n), .NONMASKABLE_SUPPRESS_I(supp), .MEMORY_ADDRESS_BITS_I(ma),
    .DATA_I(md), .DATA_O(dout), .DATA_OE_O(oe), .ADDRESS_STRAP_I(astrap), .POLARITY_STRAP_I(pstrap),
    .MASKABLE_ERROR_IRQ_O(irq), .NONMASKABLE_ERROR_IRQ_O(nmi), .HIGH_BYTE_ERROR_O(hi), .LOW_BYTE_ERROR_O(lo)
  );
  bpc_mem_model u_mem (
    .clk_i(clk), .row_strobe_bank0_n_o(rs0_n), .row_strobe_bank1_n_o(rs1_n), .column_strobe_n_o(cs_n),
    .write_strobe_n_o(ws_n), .write_enable_one_n_o(we1_n), .transfer_ack_n_o(ack_n),
    .dual_port_read_n_o(dpr_n), .memory_address_bits_o(ma), .data_o(md)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ------------------------------------------
  // apb master
  // ------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    penable <= 1'b1;
    // ready, read data and error are taken at the edge that samples ready high
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
    `CHK("pready", 1'b1, n < 20)
  endtask
  task automatic t_reset;
    apb(1'b1, bpc_pkg::OFF_STATUS, 32'h0000_00ff);
    `CHK("status write", 1'b1, err)
    apb(1'b0, bpc_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 32'h0000_0000, rd)
    apb(1'b0, 12'h008, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task automatic t_clean;
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0000_000e);
    u_mem.cycle(1'b1, 1'b0, 1'b0, 15'h0003, 16'h0103);
    u_mem.cycle(1'b0, 1'b0, 1'b0, 15'h0003, 16'h0103);
    `CHK("clean", 3'h0, {irq, hi, lo})
    u_mem.cycle(1'b0, 1'b0, 1'b0, 15'h0003, 16'h0102);
    `CHK("low lane", 4'hd, {irq, nmi, hi, lo})
    u_mem.read_port(1'b1);
    `CHK("data out", 17'h10102, {oe, dout})
    u_mem.read_port(1'b0);
  endtask
  task automatic t_fault;
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0);
    `CHK("cleared", 4'h0, {irq, nmi, hi, lo})
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0000_000e);
    u_mem.cycle(1'b1, 1'b1, 1'b0, 15'h0005, 16'h00ff);
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0000_000f);
    u_mem.cycle(1'b1, 1'b0, 1'b0, 15'h0005, 16'h1234);
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0000_000e);
    u_mem.cycle(1'b0, 1'b1, 1'b0, 15'h0005, 16'h00ff);
    `CHK("other bank", 2'h0, {irq, nmi})
    u_mem.cycle(1'b0, 1'b0, 1'b0, 15'h0005, 16'h1234);
    `CHK("forced", 4'hf, {irq, nmi, hi, lo})
    apb(1'b0, bpc_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 8'hfe, rd[7:0])
    @(posedge clk);
    supp <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("suppress", 2'h2, {irq, nmi})
    @(posedge clk);
    supp <= 1'b0;
    // rewriting with normal sense repairs the forced location
    u_mem.cycle(1'b1, 1'b0, 1'b0, 15'h0005, 16'h1234);
    u_mem.cycle(1'b0, 1'b0, 1'b0, 15'h0005, 16'h1234);
    `CHK("nmi held", 1'b0, nmi)
  endtask
  task automatic t_strap;
    // strap in: a low suppress input now holds the non-maskable latch clear
    @(posedge clk);
    {pstrap, supp} <= 2'h2;
    u_mem.cycle(1'b0, 1'b1, 1'b0, 15'h0005, 16'h00fe);
    `CHK("strap mask", 2'h2, {irq, nmi})
    @(posedge clk);
    supp <= 1'b1;
    u_mem.cycle(1'b0, 1'b1, 1'b0, 15'h0005, 16'h00fe);
    `CHK("strap open", 2'h3, {irq, nmi})
    @(posedge clk);
    {pstrap, supp} <= 2'h0;
  endtask
  task automatic t_cmd;
    // latches left set by earlier scenarios are cleared first
    apb(1'b1, bpc_pkg::OFF_CMD, 32'h0);
    u_mem.cycle(1'b1, 1'b0, 1'b1, 15'h0200, 16'h0006);
    apb(1'b0, bpc_pkg::OFF_STATUS, 32'h0);
    `CHK("cmd 400h", 8'h06, rd[7:0])
    u_mem.cycle(1'b0, 1'b0, 1'b0, 15'h0200, 16'h0006);
    `CHK("shadow", 1'b0, irq)
    u_mem.cycle(1'b1, 1'b0, 1'b1, 15'h0000, 16'h0002);
    apb(1'b0, bpc_pkg::OFF_STATUS, 32'h0);
    `CHK("cmd 0h open", 4'h6, rd[3:0])
    @(posedge clk);
    astrap <= 1'b1;
    u_mem.cycle(1'b1, 1'b0, 1'b1, 15'h0000, 16'h000a);
    apb(1'b0, bpc_pkg::OFF_STATUS, 32'h0);
    `CHK("cmd 0h strap", 4'ha, rd[3:0])
    u_mem.cycle(1'b1, 1'b0, 1'b1, 15'h0200, 16'h0006);
    apb(1'b0, bpc_pkg::OFF_CMD, 32'h0);
    `CHK("cmd 400h strap", 32'h0000_000a, rd)
  endtask
  initial
  begin
    {psel, penable, pwrite, supp, astrap, pstrap} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_clean;
    t_fault;
    t_strap;
    t_cmd;
    complete_run;
  end
  // whole run is near 370 cycles; the limit leaves wide margin
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    complete_run;
  end
endmodule
`undef CHK
`default_nettype wire
